// ### hw/gpc_port_controller.sv
/*
 * three 16-pin general-purpose pin controllers in one block: direction, output,
 * pull, function select override, synchronised input, masked interrupts, wake.
 * assumes padIn comes straight from the pads (asynchronous), the command port is
 * driven from logic on clk_sys, and peripheral signals are on clk_sys.
 */
`timescale 1ns/1ps
`include "gpc_defs.svh"
module gpc_port_controller import gpc_pkg::*; (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic controllerClockEnable,
    input wire logic bus_clock_gate_bit,
    input wire logic cmdValid,
    input wire gpc_cmd_t cmdOp,
    input wire logic [1:0] cmdGroup,
    input wire logic [15:0] cmdData,
    input wire logic rdValid,
    input wire gpc_rd_t rdSel,
    input wire logic [1:0] rdGroup,
    output logic [15:0] rdData,
    output logic rdDone,
    input wire logic [143:0] padFunctionSelect,
    input wire logic [47:0] periphOut,
    input wire logic [47:0] periphOe,
    output logic [47:0] periphIn,
    input wire logic [47:0] padIn,
    output logic [47:0] padOut,
    output logic [47:0] padOe,
    output logic [47:0] padPullEn,
    output logic [47:0] padPullUp,
    output logic [2:0] intReq,
    output logic wakeReq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [47:0] applySetClr(input logic [47:0] cur, input logic [47:0] msk,
                                                input logic doSet, input logic doClr);
        logic [47:0] res;
        res = cur;
        if (doSet) begin
            res = res | msk;
        end
        if (doClr) begin
            res = res & ~msk;
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [47:0] outEn_r, outEn_nxt, outVal_r, outVal_nxt;
    logic [47:0] pullDis_r, pullDis_nxt, pullType_r, pullType_nxt;
    logic [47:0] intEn_r, intEn_nxt, intLevel_r, intLevel_nxt, intPol_r, intPol_nxt;
    logic [47:0] intStat_r, intStat_nxt;
    logic [47:0] syncA_r, syncB_r, prev_r;
    logic [15:0] rdData_r, rdData_nxt;
    logic rdDone_r, rdDone_nxt;
    logic [2:0] intReq_r, intReq_nxt;
    logic wakeReq_r, wakeReq_nxt;
    logic clocksOn, cmdOk;
    logic [47:0] selMask, grpMask, hit, rdVec;
    logic [5:0] cmdShift, rdShift;

    // both enables must be up before any access or detection takes effect [R12]
    assign clocksOn = controllerClockEnable & bus_clock_gate_bit;
    // group index 3 does not exist, so such a command is dropped [R2]
    assign cmdOk = cmdValid & clocksOn & (cmdGroup != 2'd3);
    assign cmdShift = {cmdGroup, 4'b0000};
    assign rdShift = {rdGroup, 4'b0000};
    // a set or clear command touches only pins of its own group whose data bit is one; the output write covers the whole group [R1] [R4]
    assign selMask = {32'h0000_0000, cmdData} << cmdShift;
    assign grpMask = `GPC_GROUP_MASK << cmdShift;

    // ----------------------------------------------------------------
    // configuration and interrupt next state
    // ----------------------------------------------------------------
    always_comb begin
        outEn_nxt = applySetClr(outEn_r, selMask, cmdOk && cmdOp == GPC_CMD_OE_SET,
                                cmdOk && cmdOp == GPC_CMD_OE_CLR); // [R5] [R15] [R3]
        outVal_nxt = applySetClr(outVal_r, selMask, cmdOk && cmdOp == GPC_CMD_OUT_SET,
                                 cmdOk && cmdOp == GPC_CMD_OUT_CLR); // [R5] [R4]
        if (cmdOk && cmdOp == GPC_CMD_OUT_WRITE) begin
            outVal_nxt = (outVal_r & ~grpMask) | selMask; // whole-group write [R4]
        end
        pullDis_nxt = applySetClr(pullDis_r, selMask, cmdOk && cmdOp == GPC_CMD_PDIS_SET,
                                  cmdOk && cmdOp == GPC_CMD_PDIS_CLR); // [R16]
        pullType_nxt = applySetClr(pullType_r, selMask, cmdOk && cmdOp == GPC_CMD_PTYPE_SET,
                                   cmdOk && cmdOp == GPC_CMD_PTYPE_CLR); // [R16]
        intEn_nxt = applySetClr(intEn_r, selMask, cmdOk && cmdOp == GPC_CMD_IEN_SET,
                                cmdOk && cmdOp == GPC_CMD_IEN_CLR); // [R6]
        intLevel_nxt = applySetClr(intLevel_r, selMask, cmdOk && cmdOp == GPC_CMD_ILVL_SET,
                                   cmdOk && cmdOp == GPC_CMD_ILVL_CLR); // [R8]
        intPol_nxt = applySetClr(intPol_r, selMask, cmdOk && cmdOp == GPC_CMD_IPOL_SET,
                                 cmdOk && cmdOp == GPC_CMD_IPOL_CLR); // [R7]
    end

    // ----------------------------------------------------------------
    // interrupt detection next state
    // ----------------------------------------------------------------
    always_comb begin
        // pol 1 picks rising / high, pol 0 falling / low; edges come from the second flop
        hit = '0;
        for (int i = 0; i < `GPC_PINS; i++) begin
            if (intLevel_r[i]) begin
                hit[i] = intPol_r[i] ? syncB_r[i] : ~syncB_r[i]; // [R8]
            end else begin
                hit[i] = intPol_r[i] ? (syncB_r[i] & ~prev_r[i]) : (~syncB_r[i] & prev_r[i]); // [R7]
            end
        end
        if (!clocksOn) begin
            hit = '0; // [R12]
        end
        // edge status is sticky and an edge in the clearing cycle wins; level status follows the pin
        intStat_nxt = applySetClr(intStat_r, selMask, 1'b0, cmdOk && cmdOp == GPC_CMD_ISTAT_CLR);
        intStat_nxt = (intStat_nxt & ~intLevel_r) | hit; // [R7] [R8]
        for (int g = 0; g < `GPC_GROUPS; g++) begin
            intReq_nxt[g] = |(intStat_nxt[g*16 +: 16] & intEn_nxt[g*16 +: 16]); // [R6]
        end
        // wake looks at the always-on pins only; masked pins never wake [R11]
        wakeReq_nxt = |(intStat_nxt & intEn_nxt & `GPC_AON_PIN_MASK);
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_comb begin
        case (rdSel)
            GPC_RD_DATA: rdVec = syncB_r; // [R15] [R9]
            GPC_RD_OUT_EN: rdVec = outEn_r;
            GPC_RD_OUT_VAL: rdVec = outVal_r;
            GPC_RD_PULL_DIS: rdVec = pullDis_r;
            GPC_RD_PULL_TYPE: rdVec = pullType_r;
            GPC_RD_INT_EN: rdVec = intEn_r;
            GPC_RD_INT_LEVEL: rdVec = intLevel_r;
            GPC_RD_INT_POL: rdVec = intPol_r;
            GPC_RD_INT_STAT: rdVec = intStat_r;
            default: rdVec = '0;
        endcase
        rdDone_nxt = rdValid & clocksOn; // [R13]
        rdData_nxt = rdData_r;
        if (rdValid && clocksOn) begin
            rdData_nxt = (rdGroup == 2'd3) ? 16'h0000 : 16'(rdVec >> rdShift);
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            outEn_r <= `GPC_RST_OUT_EN; // [R17]
            outVal_r <= `GPC_RST_ZERO;
            pullDis_r <= `GPC_RST_PULL_DIS; // [R17]
            pullType_r <= `GPC_RST_PULL_TYPE; // [R17]
            intEn_r <= `GPC_RST_ZERO;
            intLevel_r <= `GPC_RST_ZERO;
            intPol_r <= `GPC_RST_ZERO;
        end else begin
            outEn_r <= outEn_nxt;
            outVal_r <= outVal_nxt;
            pullDis_r <= pullDis_nxt;
            pullType_r <= pullType_nxt;
            intEn_r <= intEn_nxt;
            intLevel_r <= intLevel_nxt;
            intPol_r <= intPol_nxt;
        end
    end

    // ----------------------------------------------------------------
    // input synchroniser
    // ----------------------------------------------------------------
    // flops start low: a pulled-up pad then looks like a rising edge, which the falling-edge reset polarity ignores
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            syncA_r <= `GPC_RST_ZERO;
            syncB_r <= `GPC_RST_ZERO;
            prev_r <= `GPC_RST_ZERO;
        end else begin
            syncA_r <= padIn; // [R9]
            syncB_r <= syncA_r; // [R9]
            prev_r <= syncB_r;
        end
    end

    // ----------------------------------------------------------------
    // interrupt registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            intStat_r <= `GPC_RST_ZERO;
            intReq_r <= 3'b000;
            wakeReq_r <= 1'b0;
        end else begin
            intStat_r <= intStat_nxt; // [R6]
            intReq_r <= intReq_nxt; // [R6]
            wakeReq_r <= wakeReq_nxt; // [R11]
        end
    end

    // ----------------------------------------------------------------
    // read registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdData_r <= 16'h0000;
            rdDone_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt; // [R13]
            rdDone_r <= rdDone_nxt; // [R13]
        end
    end

    // ----------------------------------------------------------------
    // pad side
    // ----------------------------------------------------------------
    // peripheral signals bypass the controller registers, so a mux change takes effect at once
    always_comb begin
        for (int i = 0; i < `GPC_PINS; i++) begin
            if (padFunctionSelect[i*3 +: 3] != 3'b000) begin
                padOut[i] = periphOut[i]; // [R14] [R10]
                padOe[i] = periphOe[i]; // [R10]
            end else begin
                padOut[i] = outVal_r[i]; // [R15]
                padOe[i] = outEn_r[i]; // [R15] [R3]
            end
        end
    end
    assign periphIn = syncB_r; // [R10] [R9]
    assign padPullEn = ~pullDis_r; // [R16]
    assign padPullUp = ~pullType_r; // [R16]
    assign rdData = rdData_r;
    assign rdDone = rdDone_r;
    assign intReq = intReq_r;
    assign wakeReq = wakeReq_r;

endmodule // gpc_port_controller

// ### common/gpc_defs.svh
/*
 * constants of the three-group pin controller: widths, reset values, masks.
 * assumes it is included by bare name from the package and the design file.
 */
// Summary of operation
// R1: each controller serves a group of up to 16 pins, each controllable alone or with others of the group.
// R2: the pins form three groups of sixteen, controllers 0, 1 and 2 each owning pin indices 00 to 15 of its group.
// R3: a general-purpose pin can be set as input or output with a selectable pull-up or pull-down.
// R4: one 16-bit write changes direction or output value of any subset of pins atomically, others untouched.
// R5: control registers have separate set and clear commands, ones set or clear the chosen bits.
// R6: the controller raises a per-pin interrupt and a per-pin mask suppresses pins that are not enabled; the code raises one intReq per group.
// R7: each pin interrupt can trigger on a rising or a falling edge of the synchronised input.
// R8: instead of an edge, each pin interrupt can be level-sensitive, active while the input is high or low.
// R9: every pad input passes a two-flop synchroniser before it is read or used for interrupts.
// R10: a pad handed to a peripheral takes its output from that peripheral and gives it the pad state.
// R11: pins of the always-on group can also wake the core from the ultra-low-power mode; the code wakes only from pins 40 to 47, the upper half of group 2.
// R12: software sets both the controller clock enable and the bus clock enable before configuring.
// R13: the registers are reached as a slave port of the bus matrix.
// R14: a function select of zero connects the pad to the controller, any other value to the peripheral.
// R15: an output-enable set makes the pin an output driven from the output value, a clear makes it an input.
// R16: pull disable 0 with type 0 is pull-up, with type 1 pull-down, and pull disable 1 gives no pull.
// R17: after reset every pad is an input with its pull-up enabled.
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

`define GPC_GROUP_PINS 16
`define GPC_GROUPS 3
`define GPC_PINS 48
`define GPC_SEL_W 3
`define GPC_RST_OUT_EN 48'h0000_0000_0000
`define GPC_RST_PULL_DIS 48'h0000_0000_0000
`define GPC_RST_PULL_TYPE 48'h0000_0000_0000
`define GPC_RST_ZERO 48'h0000_0000_0000
`define GPC_AON_PIN_MASK 48'hFF00_0000_0000
`define GPC_GROUP_MASK 48'h0000_0000_FFFF

`endif

// ### common/gpc_pkg.sv
/*
 * types of the pin controller: command codes and read selects.
 * assumes gpc_defs.svh lies on the include path.
 */
package gpc_pkg;
`include "gpc_defs.svh"

    typedef enum logic [4:0] {
        GPC_CMD_OE_SET = 5'h00,
        GPC_CMD_OE_CLR = 5'h01,
        GPC_CMD_OUT_SET = 5'h02,
        GPC_CMD_OUT_CLR = 5'h03,
        GPC_CMD_OUT_WRITE = 5'h04,
        GPC_CMD_PDIS_SET = 5'h05,
        GPC_CMD_PDIS_CLR = 5'h06,
        GPC_CMD_PTYPE_SET = 5'h07,
        GPC_CMD_PTYPE_CLR = 5'h08,
        GPC_CMD_IEN_SET = 5'h09,
        GPC_CMD_IEN_CLR = 5'h0A,
        GPC_CMD_ILVL_SET = 5'h0B,
        GPC_CMD_ILVL_CLR = 5'h0C,
        GPC_CMD_IPOL_SET = 5'h0D,
        GPC_CMD_IPOL_CLR = 5'h0E,
        GPC_CMD_ISTAT_CLR = 5'h0F
    } gpc_cmd_t;

    typedef enum logic [3:0] {
        GPC_RD_DATA = 4'h0,
        GPC_RD_OUT_EN = 4'h1,
        GPC_RD_OUT_VAL = 4'h2,
        GPC_RD_PULL_DIS = 4'h3,
        GPC_RD_PULL_TYPE = 4'h4,
        GPC_RD_INT_EN = 4'h5,
        GPC_RD_INT_LEVEL = 4'h6,
        GPC_RD_INT_POL = 4'h7,
        GPC_RD_INT_STAT = 4'h8
    } gpc_rd_t;
endpackage

// ### test/gpc_port_props.sv
/* checker of the pin controller ports.
   assumes it is bound into gpc_port_controller, one clock domain. */
`timescale 1ns/1ps
module gpc_port_props import gpc_pkg::*; (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic controllerClockEnable,
    input wire logic bus_clock_gate_bit,
    input wire logic cmdValid,
    input wire gpc_cmd_t cmdOp,
    input wire logic [1:0] cmdGroup,
    input wire logic [15:0] cmdData,
    input wire logic rdValid,
    input wire logic [1:0] rdGroup,
    input wire logic [15:0] rdData,
    input wire logic rdDone,
    input wire logic [143:0] padFunctionSelect,
    input wire logic [47:0] padOe,
    input wire logic [47:0] padPullEn,
    input wire logic [47:0] padPullUp,
    input wire logic [2:0] intReq,
    input wire logic wakeReq
);
    logic live;
    logic ownG1;
    assign live = controllerClockEnable && bus_clock_gate_bit;
    // group 1 pads only: a peripheral owning a pad would hide the controller direction
    assign ownG1 = padFunctionSelect[95:48] == 48'h0000_0000_0000;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    rd_answer_a: assert property (rdValid && live |=> rdDone)
        else $error("read not answered");
    rd_quiet_a: assert property (!(rdValid && live) |=> !rdDone)
        else $error("read answer without request");
    rd_nogroup_a: assert property (rdValid && live && rdGroup == 2'h3 |=> rdData == 16'h0000)
        else $error("missing group read not zero");
    oe_set_a: assert property (cmdValid && live && cmdGroup == 2'h1 && cmdOp == GPC_CMD_OE_SET && ownG1
        |=> !ownG1 || padOe[31:16] == ($past(padOe[31:16]) | $past(cmdData))) else $error("direction set wrong");
    oe_clr_a: assert property (cmdValid && live && cmdGroup == 2'h1 && cmdOp == GPC_CMD_OE_CLR && ownG1
        |=> !ownG1 || padOe[31:16] == ($past(padOe[31:16]) & ~$past(cmdData))) else $error("direction clear wrong");
    gated_dir_a: assert property (!live && ownG1 |=> !ownG1 || $stable(padOe[31:16]))
        else $error("direction changed while gated");
    pull_hold_a: assert property (!(cmdValid && live) |=> $stable(padPullEn) && $stable(padPullUp))
        else $error("pull changed without command");
    pull_reset_a: assert property ($rose(rstn) |-> (padPullEn & padPullUp) == 48'hFFFF_FFFF_FFFF)
        else $error("pads not pulled up after reset");
    wake_group_a: assert property (wakeReq |-> intReq[2])
        else $error("wake without group interrupt");
endmodule // gpc_port_props
bind gpc_port_controller gpc_port_props gpc_port_props_i (.clk_sys(clk_sys), .rstn(rstn),
    .controllerClockEnable(controllerClockEnable), .bus_clock_gate_bit(bus_clock_gate_bit), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdGroup(cmdGroup), .cmdData(cmdData), .rdValid(rdValid), .rdGroup(rdGroup), .rdData(rdData),
    .rdDone(rdDone), .padFunctionSelect(padFunctionSelect), .padOe(padOe), .padPullEn(padPullEn),
    .padPullUp(padPullUp), .intReq(intReq), .wakeReq(wakeReq));

// ### test/gpc_pad_model.sv
/* pad side: resolves each pad from controller drive, an outside driver and the pulls.
   assumes the outside drive comes from the bench on clk_sys. */
`timescale 1ns/1ps
module gpc_pad_model (
    input wire logic clk_sys,
    input wire logic [47:0] padOut,
    input wire logic [47:0] padOe,
    input wire logic [47:0] padPullEn,
    input wire logic [47:0] padPullUp,
    input wire logic [47:0] extOe,
    input wire logic [47:0] extOut,
    output logic [47:0] padIn
);
    logic [47:0] floatLvl_r = 48'h0000_0000_0000;
    // an undriven unpulled pad never holds a steady value
    always @(posedge clk_sys) floatLvl_r <= ~floatLvl_r;
    always_comb begin
        for (int i = 0; i < 48; i++) begin
            if (padOe[i]) padIn[i] = padOut[i];
            else if (extOe[i]) padIn[i] = extOut[i];
            else if (padPullEn[i]) padIn[i] = padPullUp[i];
            else padIn[i] = floatLvl_r[i];
        end
    end
endmodule // gpc_pad_model

// ### test/gpc_port_controller_tb.sv
/* bench of the pin controller against a behavioural register model.
   assumes gpc_pad_model on the pads and the checker bound from its own file. */
`timescale 1ns/1ps
module gpc_port_controller_tb import gpc_pkg::*; ;
    logic clk_sys = 1'b0, rstn = 1'b0, controllerClockEnable = 1'b1, bus_clock_gate_bit = 1'b1;
    logic cmdValid = 1'b0, rdValid = 1'b0, rdDone, wakeReq;
    gpc_cmd_t cmdOp = GPC_CMD_OE_SET;
    gpc_rd_t rdSel = GPC_RD_DATA;
    logic [1:0] cmdGroup = 2'h0, rdGroup = 2'h0;
    logic [15:0] cmdData = 16'h0000, rdData;
    logic [143:0] padFunctionSelect = 144'h0;
    logic [47:0] periphOut = 48'h0, periphOe = 48'h0, extOe = 48'h0, extOut = 48'h0;
    logic [47:0] periphIn, padIn, padOut, padOe, padPullEn, padPullUp;
    logic [2:0] intReq;
    int n_fail = 0, checked = 0, seed = 32'h54be, op, g, en;
    int m[9][4];
    gpc_port_controller gpc_port_controller_i (.clk_sys(clk_sys), .rstn(rstn), .cmdValid(cmdValid),
        .controllerClockEnable(controllerClockEnable), .bus_clock_gate_bit(bus_clock_gate_bit), .cmdOp(cmdOp),
        .cmdGroup(cmdGroup), .cmdData(cmdData), .rdValid(rdValid), .rdSel(rdSel), .rdGroup(rdGroup),
        .rdData(rdData), .rdDone(rdDone), .padFunctionSelect(padFunctionSelect), .periphOut(periphOut),
        .periphOe(periphOe), .periphIn(periphIn), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullEn(padPullEn), .padPullUp(padPullUp), .intReq(intReq), .wakeReq(wakeReq));
    gpc_pad_model gpc_pad_model_i (.clk_sys(clk_sys), .padOut(padOut), .padOe(padOe), .padPullEn(padPullEn),
        .padPullUp(padPullUp), .extOe(extOe), .extOut(extOut), .padIn(padIn));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ----------------
    // shared tasks
    // ----------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    function automatic int selOf(input int op);
        return (op == 4) ? 2 : (op < 4) ? op / 2 + 1 : (op - 5) / 2 + 3;
    endfunction
    function automatic logic [47:0] pads(input int s);
        return {m[s][2][15:0], m[s][1][15:0], m[s][0][15:0]};
    endfunction
    task automatic cmd(input int op, input int g, input int d);
        @(negedge clk_sys);
        cmdValid = 1'b1;
        cmdOp = gpc_cmd_t'(op);
        cmdGroup = g[1:0];
        cmdData = d[15:0];
        if (controllerClockEnable && bus_clock_gate_bit && g < 3 && op < 15) begin
            if (op == 4) m[2][g] = d & 16'hFFFF;
            else if ((op < 4) == (op % 2 == 0)) m[selOf(op)][g] |= d & 16'hFFFF;
            else m[selOf(op)][g] &= ~d;
        end
        @(negedge clk_sys);
        cmdValid = 1'b0;
    endtask
    task automatic rd(input int s, input int g, input logic [15:0] exp);
        @(negedge clk_sys);
        rdValid = 1'b1;
        rdSel = gpc_rd_t'(s);
        rdGroup = g[1:0];
        @(negedge clk_sys);
        rdValid = 1'b0;
        chk(rdDone, 48'h1, "read done");
        chk(rdData, exp, "read data");
    endtask
    initial begin
        #100_000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        rstn = 1'b1;
        chk(padOe, 48'h0, "reset direction");
        for (int s = 1; s < 9; s++) for (int k = 0; k < 4; k++) rd(s, k, 16'h0000);
        rd(0, 0, 16'hFFFF);
        extOe = 48'h0100_0000_FFFF;
        extOut = 48'h0000_0000_1234;
        rd(0, 0, 16'hFFFF);
        rd(0, 0, 16'h1234);
        $display("reset and input test done");
        cmd(GPC_CMD_IEN_SET, 2, 16'h0100);
        cmd(GPC_CMD_IPOL_SET, 2, 16'h0100);
        cmd(GPC_CMD_ISTAT_CLR, 2, 16'hFFFF);
        extOut[40] = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(intReq, 48'h0, "edge too early");
        @(negedge clk_sys);
        chk({wakeReq, intReq}, 48'hC, "rising edge and wake");
        rd(8, 2, 16'h0100);
        cmd(GPC_CMD_ISTAT_CLR, 2, 16'h0100);
        chk(intReq, 48'h0, "status cleared");
        cmd(GPC_CMD_IEN_CLR, 2, 16'h0100);
        cmd(GPC_CMD_IPOL_CLR, 2, 16'h0100);
        extOut[40] = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(intReq, 48'h0, "masked");
        cmd(GPC_CMD_IEN_SET, 2, 16'h0100);
        @(negedge clk_sys);
        chk(intReq, 48'h4, "falling edge");
        cmd(GPC_CMD_ILVL_SET, 2, 16'h0100);
        cmd(GPC_CMD_ISTAT_CLR, 2, 16'h0100);
        repeat (2) @(negedge clk_sys);
        chk(intReq, 48'h4, "level low");
        extOut[40] = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(intReq, 48'h0, "level gone");
        cmd(GPC_CMD_IPOL_SET, 2, 16'h0100);
        @(negedge clk_sys);
        chk(intReq, 48'h4, "level high");
        $display("interrupt test done");
        for (int k = 0; k < 300; k++) begin
            op = $unsigned($random(seed)) % 15;
            g = $unsigned($random(seed)) % 4;
            en = $random(seed);
            controllerClockEnable = en[2:0] != 3'h0;
            bus_clock_gate_bit = en[5:3] != 3'h0;
            cmd(op, g, $random(seed));
            controllerClockEnable = 1'b1;
            bus_clock_gate_bit = 1'b1;
            chk(padOe, pads(1), "direction");
            chk(padOut, pads(2), "output value");
            chk(padPullEn, ~pads(3), "pull enable");
            chk(padPullUp, ~pads(4), "pull type");
            rd(selOf(op), g, m[selOf(op)][g][15:0]);
        end
        $display("random command test done");
        for (int j = 0; j < 7; j++) begin
            padFunctionSelect[17:15] = j[2:0] + 3'h1;
            en = $random(seed);
            periphOut[5] = en[0];
            periphOe[5] = en[1];
            extOut[5] = en[2];
            repeat (3) @(negedge clk_sys);
            chk({padOe[5], padOut[5]}, {en[1], en[0]}, "peripheral drive");
            chk(periphIn[5], en[1] ? en[0] : en[2], "peripheral input");
        end
        padFunctionSelect = 144'h0;
        @(negedge clk_sys);
        chk(padOe, pads(1), "controller owns pad again");
        $display("function select test done");
        final_report();
    end
endmodule // gpc_port_controller_tb
